// [core/fpu_error_defines.vh]
/*
 Constants for the numeric error reporting block: exception class bit
 positions, instruction kinds and pulse/window timing counts.
 Assumes a 10 MHz core clock (mclk).
*/
`ifndef FPU_ERROR_DEFINES_VH
`define FPU_ERROR_DEFINES_VH

// Exception class bit positions within the six-bit exception vector
`define EXC_INVALID      3'd0
`define EXC_ZERO_DIVIDE  3'd1
`define EXC_DENORMAL     3'd2
`define EXC_OVERFLOW     3'd3
`define EXC_UNDERFLOW    3'd4
`define EXC_INEXACT      3'd5
`define EXC_COUNT        6

// Instruction kinds presented on instr_kind
`define KIND_WAIT        2'h0
`define KIND_FPU         2'h1
`define KIND_NOWAIT      2'h2

// Timing
`define CLK_PERIOD_NS    100
`define PULSE_MIN_NS     100
`define PULSE_CYCLES     ((`PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WINDOW_CYCLES    3

`endif

// [core/exc_classifier.v]
/*
 Classifies raw exception detections of one floating-point instruction into
 the six classes and gates them with the control-word masks.
 Assumes inputs come from logic on the same clock.
*/
`timescale 1ns/1ns
`include "fpu_error_defines.vh"

module exc_classifier (
   input  wire       stack_fault_exc,
   input  wire       arith_invalid_exc,
   input  wire [4:0] other_exc,
   input  wire [5:0] exc_mask,
   output wire [5:0] exc_class,
   output wire       unmasked_any
);

   // Invalid merges both subtypes; the rest map one to one
   assign exc_class    = {other_exc, stack_fault_exc | arith_invalid_exc}; // RULE13
   assign unmasked_any = |(exc_class & ~exc_mask);

endmodule // exc_classifier

// [core/fpu_error_pin_signaling.v]
/*
 Compatibility-mode numeric error reporting: error output pin, freeze at
 wait/floating-point instructions, no-wait brief pulse and interrupt window.
 Assumes an instruction sequencer on mclk issues instr_start pulses and
 waits on instr_stall; pins ignore_numeric_error_in and maskable_irq_in are
 asynchronous and synchronised here.
*/
// What this block and its external logic do
// RULE1: No-wait raises error output when exception pending
// RULE2: No-wait then drops error output, continues
// RULE3: Every instruction samples interrupts in window; an all-immediate no-wait goes straight to ST_RUN without one
// RULE4: No-wait window opens after error raise
// RULE5: Late interrupt taken at next boundary
// RULE6: Deferred exception raises output at next instruction
// RULE7: No pulse when cleared; no change when high
// RULE8: All-immediate variant raises output on detection
// RULE9: Pending exception freezes next wait/fpu instruction
// RULE10: Frozen until handler clears exception state
// RULE11: All-immediate: no-wait has no sampling window
// RULE12: Interrupt input ignored while flag cleared
// RULE13: Six exception classes with invalid subtypes
// RULE14: External logic latches even brief pulses
// RULE15: Active only while native report bit clear
// RULE16: Ignore-error input suppresses output and freeze
// RULE17: Clearing exception drops error output
// RULE18: External logic clears request, sets ignore
// RULE19: External logic drops ignore when output low
// RULE20: Brief pulse lasts at least one cycle
`timescale 1ns/1ns
`include "fpu_error_defines.vh"

module fpu_error_pin_signaling (
   input  wire       mclk,
   input  wire       reset,
   input  wire       all_immediate_mode,
   input  wire       native_error_report_bit,
   input  wire       irq_enable_flag,
   input  wire       maskable_irq_in,
   input  wire       ignore_numeric_error_in,
   input  wire       instr_start,
   input  wire [1:0] instr_kind,
   input  wire       instr_done,
   input  wire       exc_detect,
   input  wire       exc_immediate,
   input  wire       stack_fault_exc,
   input  wire       arith_invalid_exc,
   input  wire [4:0] other_exc,
   input  wire [5:0] exc_mask,
   input  wire       exc_clear,
   output reg        fpu_error_out,
   output wire       instr_stall,
   output reg        irq_take,
   output reg  [5:0] exc_status
);

   localparam ST_IDLE   = 4'b0001;
   localparam ST_PULSE  = 4'b0010;
   localparam ST_WINDOW = 4'b0100;
   localparam ST_RUN    = 4'b1000;

   // Window of three cycles lets a no-wait catch the request its own pulse raised
   localparam integer PULSE_LOAD  = `PULSE_CYCLES - 1;
   localparam integer WINDOW_LOAD = `WINDOW_CYCLES - 1;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   reg        irq_meta_ff;
   reg        irq_sync_ff;
   reg        ign_meta_ff;
   reg        ign_sync_ff;

   always @(posedge mclk) begin
      if (reset) begin
         irq_meta_ff <= 1'b0;
         irq_sync_ff <= 1'b0;
         ign_meta_ff <= 1'b1;
         ign_sync_ff <= 1'b1;
      end else begin
         irq_meta_ff <= maskable_irq_in;
         irq_sync_ff <= irq_meta_ff;
         ign_meta_ff <= ignore_numeric_error_in;
         ign_sync_ff <= ign_meta_ff;
      end
   end

   // Pin is active low; ign_sync_ff high means not ignoring
   wire ignoring = ~ign_sync_ff;
   wire compat   = ~native_error_report_bit; // RULE15
   wire irq_seen = irq_sync_ff & irq_enable_flag; // RULE12

   ////////////////////////////////////////////////////////////////////////////
   // Exception classification
   wire [5:0] exc_class;
   wire       unmasked_any;

   exc_classifier u_classifier (
      .stack_fault_exc   (stack_fault_exc),
      .arith_invalid_exc (arith_invalid_exc),
      .other_exc         (other_exc),
      .exc_mask          (exc_mask),
      .exc_class         (exc_class),
      .unmasked_any      (unmasked_any)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Pending exception state
   reg        pending_ff;
   reg        reported_ff;
   reg        nxt_pending;
   reg        nxt_reported;
   reg  [5:0] nxt_status;
   wire       new_exc   = exc_detect & unmasked_any;
   wire       report_now = all_immediate_mode | exc_immediate; // RULE8
   // Reaching a wait or fpu instruction reports a deferred exception even if it freezes there
   wire       fpu_start = instr_start & ((instr_kind == `KIND_FPU) | (instr_kind == `KIND_WAIT));

   always @* begin
      nxt_pending  = pending_ff;
      nxt_reported = reported_ff;
      nxt_status   = exc_status;
      if (exc_clear) begin
         nxt_pending  = 1'b0; // RULE17
         nxt_reported = 1'b0;
         nxt_status   = 6'h00;
      end
      // Detection wins over a clear in the same cycle
      if (exc_detect) begin
         nxt_status = nxt_status | exc_class; // RULE13
      end
      if (new_exc) begin
         nxt_pending  = 1'b1;
         nxt_reported = report_now; // RULE8
      end else if (pending_ff & ~exc_clear & fpu_start) begin
         nxt_reported = 1'b1; // RULE6
      end
   end

   always @(posedge mclk) begin
      if (reset) begin
         pending_ff  <= 1'b0;
         reported_ff <= 1'b0;
         exc_status  <= 6'h00;
      end else begin
         pending_ff  <= nxt_pending;
         reported_ff <= nxt_reported;
         exc_status  <= nxt_status;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Instruction sequencing: no-wait pulse and interrupt window
   reg  [3:0] state_ff;
   reg  [3:0] nxt_state;
   reg  [1:0] cnt_ff;
   reg  [1:0] nxt_cnt;
   reg        nxt_pulse;
   reg        nxt_irq_take;
   reg        late_irq_ff;
   reg        nxt_late_irq;

   // Freeze: blocked on wait/fpu while an unignored exception is pending
   wire block_kind = (instr_kind == `KIND_WAIT) | (instr_kind == `KIND_FPU);
   assign instr_stall = instr_start & block_kind & compat & pending_ff
                        & ~ignoring & (state_ff == ST_IDLE); // RULE9 RULE10

   always @* begin
      nxt_state     = state_ff;
      nxt_cnt       = cnt_ff;
      nxt_pulse     = 1'b0;
      nxt_irq_take  = 1'b0;
      nxt_late_irq  = late_irq_ff;
      case (state_ff)
         ST_IDLE: begin
            // Boundary: a missed request, or the one a frozen start waits for, is taken here
            if ((late_irq_ff | instr_stall) & irq_seen) begin
               nxt_irq_take = 1'b1; // RULE5 RULE10
               nxt_late_irq = 1'b0;
            end else if (instr_start & ~instr_stall) begin
               if ((instr_kind == `KIND_NOWAIT) & compat & pending_ff & ~ignoring
                   & ~all_immediate_mode & ~reported_ff & ~exc_clear) begin
                  nxt_pulse = 1'b1; // RULE1 RULE7
                  nxt_cnt   = PULSE_LOAD[1:0];
                  nxt_state = ST_PULSE;
               end else if ((instr_kind == `KIND_NOWAIT) & all_immediate_mode) begin
                  nxt_state = ST_RUN; // RULE11
               end else begin
                  nxt_cnt   = WINDOW_LOAD[1:0];
                  nxt_state = ST_WINDOW;
               end
            end
         end
         ST_PULSE: begin
            // Hold the pulse its minimum width, then open the window
            if (cnt_ff != 2'h0) begin
               nxt_pulse = 1'b1; // RULE20
               nxt_cnt   = cnt_ff - 2'h1;
            end else begin
               nxt_cnt   = WINDOW_LOAD[1:0];
               nxt_state = ST_WINDOW; // RULE4 RULE2
            end
         end
         ST_WINDOW: begin
            if (irq_seen) begin
               nxt_irq_take = 1'b1; // RULE3
               nxt_state    = ST_RUN;
            end else if (cnt_ff == 2'h0) begin
               nxt_state = ST_RUN;
            end else begin
               nxt_cnt = cnt_ff - 2'h1;
            end
         end
         ST_RUN: begin
            if (irq_seen) begin
               nxt_late_irq = 1'b1; // RULE5
            end
            if (instr_done) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge mclk) begin
      if (reset) begin
         state_ff     <= ST_IDLE;
         cnt_ff       <= 2'h0;
         irq_take     <= 1'b0;
         late_irq_ff  <= 1'b0;
      end else begin
         state_ff     <= nxt_state;
         cnt_ff       <= nxt_cnt;
         irq_take     <= nxt_irq_take;
         late_irq_ff  <= nxt_late_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Error output: steady report or no-wait pulse; ignoring blocks a raise but never drops
   // a raised output, else the outside ignore flop, cleared by a low output, would oscillate
   always @(posedge mclk) begin
      if (reset) begin
         fpu_error_out <= 1'b0;
      end else begin
         fpu_error_out <= compat & ((nxt_pending & nxt_reported & (fpu_error_out | ~ignoring))
                          | (nxt_pulse & ~ignoring)); // RULE16 RULE6 RULE17
      end
   end

endmodule // fpu_error_pin_signaling

// [bench/err_pin_monitor.sv]
/* Checker on the error pin block ports.
   Assumes one clock, mclk, with a synchronous active-high reset. */
`timescale 1ns/1ns
module err_pin_monitor (
   input wire       mclk,
   input wire       reset,
   input wire       all_immediate_mode,
   input wire       native_error_report_bit,
   input wire       irq_enable_flag,
   input wire       ignore_numeric_error_in,
   input wire       exc_detect,
   input wire       stack_fault_exc,
   input wire       arith_invalid_exc,
   input wire [4:0] other_exc,
   input wire [5:0] exc_mask,
   input wire       exc_clear,
   input wire       fpu_error_out,
   input wire       instr_stall,
   input wire       irq_take,
   input wire [5:0] exc_status
);
   wire [5:0] cls = {other_exc, stack_fault_exc | arith_invalid_exc};
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   a_reset_quiet: assert property (disable iff (1'b0)
      reset |=> !fpu_error_out && !irq_take && exc_status == 6'h00) else $error("reset state");
   a_native_silent: assert property (native_error_report_bit && $past(native_error_report_bit)
      |-> !fpu_error_out) else $error("output in native mode");
   a_irq_masked: assert property (!$past(irq_enable_flag) |-> !irq_take) else $error("masked take");
   a_clear_drop: assert property (exc_clear && !exc_detect |=> !fpu_error_out) else $error("no drop");
   a_take_single: assert property (irq_take |=> !irq_take) else $error("long take");
   a_imm_raise: assert property (all_immediate_mode && !native_error_report_bit && exc_detect
      && |(cls & ~exc_mask) && ignore_numeric_error_in && $past(ignore_numeric_error_in, 2)
      |=> fpu_error_out) else $error("no raise");
   a_stall_cause: assert property (instr_stall |-> !native_error_report_bit && exc_status != 6'h00)
      else $error("stall without cause");
   a_status_sticky: assert property (exc_detect |=> (exc_status & $past(cls)) == $past(cls))
      else $error("class lost");
   cover property ($rose(fpu_error_out) ##1 $fell(fpu_error_out));
   cover property (instr_stall ##1 !instr_stall);
   cover property (irq_take);
endmodule // err_pin_monitor
bind fpu_error_pin_signaling err_pin_monitor err_pin_monitor_i (.*);

// [bench/err_latch_model.sv]
/* Model of the external error latch and ignore-error flop.
   Assumes the bench pulses port_acc for the handler's port access. */
`timescale 1ns/1ns
module err_latch_model (
   input  wire mclk,
   input  wire reset,
   input  wire fpu_error_out,
   input  wire port_acc,
   output reg  maskable_irq_in,
   output reg  ignore_numeric_error_in
);
   // Edge capture: a one-cycle pulse is caught, and a port access clears it until the next rising edge of fpu_error_out
   reg err_prev_ff;
   always @(posedge mclk) begin
      err_prev_ff <= fpu_error_out;
      if (reset || port_acc) begin
         maskable_irq_in <= 1'b0;
      end else if (fpu_error_out && !err_prev_ff) begin
         maskable_irq_in <= 1'b1;
      end
   end
   // Ignore can never stay active with the error output low
   always @(posedge mclk) begin
      if (reset || !fpu_error_out) begin
         ignore_numeric_error_in <= 1'b1;
      end else if (port_acc) begin
         ignore_numeric_error_in <= 1'b0;
      end
   end
endmodule // err_latch_model

// [bench/fpu_error_pin_signaling_bench.sv]
/* Bench for the error pin block with the external latch model.
   Assumes design, checker and model files are compiled first. */
`timescale 1ns/1ns
`include "fpu_error_defines.vh"
module fpu_error_pin_signaling_bench;
   reg        mclk = 0, reset = 1, all_immediate_mode = 0, native_error_report_bit = 0, irq_enable_flag = 1;
   reg        instr_start = 0, instr_done = 0, exc_detect = 0, exc_immediate = 0, exc_clear = 0, port_acc = 0;
   reg        stack_fault_exc = 0, arith_invalid_exc = 0, last_err = 0;
   reg  [1:0] instr_kind = 0;
   reg  [4:0] other_exc = 0;
   reg  [5:0] exc_mask = 0, cls = 0;
   reg  [1:0] q[$];
   wire       maskable_irq_in, ignore_numeric_error_in, fpu_error_out, instr_stall, irq_take;
   wire [5:0] exc_status;
   integer    mismatches = 0, checks_done = 0, i, n;
   fpu_error_pin_signaling fpu_error_pin_signaling_i (.*);
   err_latch_model err_latch_model_i (.*);
   always #50 mclk = ~mclk;
   task chk(input [5:0] seen, input [5:0] want);
      begin
         checks_done = checks_done + 1;
         if (seen !== want) begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
         end
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d mismatches %0d", checks_done, mismatches);
         if (mismatches == 0 && checks_done > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   task run(input [1:0] k, input imm, input [5:0] c);
      begin
         instr_kind = k;
         instr_start = 1;
         @(negedge mclk);
         instr_start = 0;
         exc_detect = |c;
         exc_immediate = imm;
         {other_exc, arith_invalid_exc} = c;
         stack_fault_exc = c[0] & ($urandom % 2);
         @(negedge mclk);
         exc_detect = 0;
         repeat (4) @(negedge mclk);
         instr_done = 1;
         @(negedge mclk);
         instr_done = 0;
         @(negedge mclk);
      end
   endtask
   // Handler: clear first, then port access, then re-enable once sync settles
   task handle;
      begin
         exc_clear = 1;
         @(negedge mclk);
         exc_clear = 0;
         port_acc = 1;
         @(negedge mclk);
         port_acc = 0;
         repeat (4) @(negedge mclk);
         irq_enable_flag = 1;
      end
   endtask
   task wait_q;
      begin
         n = 0;
         while (q.size() > 0 && n < 60) begin
            @(negedge mclk);
            n = n + 1;
         end
         chk(q.size(), 0);
      end
   endtask
   // Every output event takes the oldest note; a take also clears the flag
   always @(negedge mclk) begin
      if (!reset && fpu_error_out !== last_err) begin
         chk(q.size() ? q.pop_front() : 2'd0, fpu_error_out ? 2'd1 : 2'd2);
         last_err = fpu_error_out;
      end
      if (!reset && irq_take === 1'b1) begin
         chk(q.size() ? q.pop_front() : 2'd0, 2'd3);
         irq_enable_flag = 0;
      end
   end
   // Whole run is under two hundred cycles; this cuts a hang
   initial begin
      #1000000;
      mismatches = mismatches + 1;
      finish_test;
   end
   initial begin
      void'($urandom(32'h4c26));
      repeat (5) @(negedge mclk);
      reset = 0;
      cls = 6'h01 << ($urandom % 6);
      exc_mask = $urandom & ~cls;
      run(`KIND_FPU, 0, cls);
      chk(fpu_error_out, 0);
      q = {2'd1, 2'd2, 2'd3};
      run(`KIND_NOWAIT, 0, 0);
      wait_q;
      handle;
      ////////////////////////////////////////
      run(`KIND_FPU, 0, cls);
      q = {2'd1, 2'd3};
      instr_kind = `KIND_FPU;
      instr_start = 1;
      @(negedge mclk);
      chk(instr_stall, 1);
      wait_q;
      chk(instr_stall, 1);
      q = {2'd2};
      handle;
      instr_start = 0;
      chk(instr_stall, 0);
      instr_done = 1;
      @(negedge mclk);
      instr_done = 0;
      @(negedge mclk);
      ////////////////////////////////////////
      all_immediate_mode = 1;
      irq_enable_flag = 0;
      q = {2'd1};
      run(`KIND_FPU, $urandom % 2, cls);
      wait_q;
      run(`KIND_NOWAIT, 0, 0);
      q = {2'd2};
      handle;
      exc_mask = 6'h3f;
      for (i = 0; i < 6; i = i + 1) begin
         run(`KIND_FPU, i % 2, 6'h01 << i);
         chk(exc_status[i], 1);
      end
      handle;
      native_error_report_bit = 1;
      exc_mask = 0;
      run(`KIND_FPU, 1, cls);
      chk(fpu_error_out, 0);
      handle;
      native_error_report_bit = 0;
      all_immediate_mode = 0;
      // Handler raises ignore before clearing: no freeze, output held until the clear
      q = {2'd1, 2'd3};
      run(`KIND_FPU, 1, cls);
      wait_q;
      port_acc = 1;
      @(negedge mclk);
      port_acc = 0;
      repeat (2) @(negedge mclk);
      instr_kind = `KIND_WAIT;
      instr_start = 1;
      #1 chk(instr_stall, 0);
      @(negedge mclk);
      instr_start = 0;
      repeat (3) @(negedge mclk);
      instr_done = 1;
      @(negedge mclk);
      instr_done = 0;
      chk(fpu_error_out, 1);
      q = {2'd2};
      handle;
      run(`KIND_NOWAIT, 0, 0);
      chk(q.size(), 0);
      finish_test;
   end
endmodule // fpu_error_pin_signaling_bench
